// *** fma_pkg.sv ***
// fma_pkg: constants, types and register map of the float mode accumulator
// assumes a 16-bit host word; bit numbers here count from the lsb
package fma_pkg;

  // float mode bit of a status word: bit 9 counting from the msb
  localparam int FM_BIT = 6;
  localparam logic [15:0] ACC_PTR_ADDR = 16'h0001;
  localparam logic [1:0] LAST_WORD = 2'h2;

  // apb register map, byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_AWORD = 12'h008;
  localparam int CTRL_FPEN_BIT = 0;
  localparam logic CTRL_FPEN_RST = 1'b1;
  localparam int ST_FM_BIT = 0;
  localparam int ST_OVF_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_ARM_BIT = 3;

  // largest normalized results on exponent overflow
  localparam logic [15:0] OVF_POS_HI = 16'h7FFF;
  localparam logic [15:0] OVF_POS_LO = 16'hFFFF;
  localparam logic [15:0] OVF_NEG_HI = 16'h8000;
  localparam logic [15:0] OVF_NEG_LO = 16'h0001;
  localparam logic [15:0] OVF_EXP = 16'h7FFF;

  // mantissa thresholds in the 34-bit working width, exponent limits in 18 bits
  localparam logic signed [33:0] MANT_ONE = 34'sh080000000;
  localparam logic signed [33:0] MANT_NONE = -34'sh080000000;
  localparam logic signed [33:0] MANT_HALF = 34'sh040000000;
  localparam logic signed [33:0] MANT_NHALF = -34'sh040000000;
  localparam logic signed [17:0] EXP_MAX = 18'sh07FFF;
  localparam logic signed [17:0] EXP_MIN = -18'sh08000;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_WD_C0 = 4'h1,
    CMD_WD_D8 = 4'h2,
    CMD_LDX = 4'h3,
    CMD_BRANCH = 4'h4,
    CMD_INT_ENTRY = 4'h5,
    CMD_PSW_READ = 4'h6,
    CMD_LOAD = 4'h7,
    CMD_STORE = 4'h8,
    CMD_ADD = 4'h9,
    CMD_SUB = 4'hA
  } fma_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PTR = 3'b001,
    ST_XFER = 3'b011,
    ST_CALC = 3'b010,
    ST_DONE = 3'b110
  } fma_state_t;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] ex;
  } fma_fp_t;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fma_mem_t;

  typedef struct packed {
    fma_fp_t val;
    logic ovf;
  } fma_res_t;

endpackage : fma_pkg

// *** fma_unit.sv ***
// fma_unit: float mode flag, scratch float accumulator, load/store/add/sub
// assumes a sequencer on clk_sys, a memory port with one-cycle ack, apb host
`timescale 1ns/10ps

module fma_unit (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_valid,
  input wire fma_pkg::fma_cmd_t cmd,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  output logic cmd_ready,
  output logic res_valid,
  output logic [15:0] res_a,
  output logic ovf_ind,
  output logic float_mode_flag,
  output logic psd_fm_save,
  input wire logic compute_run,
  output logic mem_req,
  output fma_pkg::fma_mem_t mem_bus,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);

  fma_pkg::fma_state_t st_r;
  fma_pkg::fma_cmd_t op_r;
  fma_pkg::fma_fp_t scratch_float_acc_r;
  fma_pkg::fma_fp_t opd_r;
  fma_pkg::fma_mem_t mem_r;
  fma_pkg::fma_res_t calc;
  logic fm_r, arm_r, ovf_r, fm_save_r, ready_r, res_valid_r, mem_req_r, wr_r;
  logic fpen_r, run_s1_r, run_s2_r, run_s3_r, pend_stop_r, pend_run_r;
  logic [15:0] res_a_r, base_r;
  logic [1:0] idx_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic take, fm_tgt, float_go, run_edge, stop_edge, pend_any;

  // add or subtract with prealignment and postnormalization
  function automatic fma_pkg::fma_res_t fma_addsub(
    input fma_pkg::fma_fp_t a,
    input fma_pkg::fma_fp_t b,
    input logic sub
  );
    logic signed [33:0] ma, mb, s;
    logic signed [17:0] ea, eb, e;
    fma_pkg::fma_res_t r;
    ma = {{2{a.hi[15]}}, a.hi, a.lo};
    mb = {{2{b.hi[15]}}, b.hi, b.lo};
    ea = {{2{a.ex[15]}}, a.ex};
    eb = {{2{b.ex[15]}}, b.ex};
    r = '0;
    if (sub) mb = -mb;
    if (mb == '0) begin
      s = ma;
      e = ea;
    end else if (ma == '0) begin
      s = mb;
      e = eb;
    end else if (ea >= eb) begin
      s = ma + (mb >>> (ea - eb));
      e = ea;
    end else begin
      s = mb + (ma >>> (eb - ea));
      e = eb;
    end
    for (int i = 0; i < 2; i++) begin
      if (s >= fma_pkg::MANT_ONE || s <= fma_pkg::MANT_NONE) begin
        s = s >>> 1;
        e = e + 18'sd1;
      end
    end
    for (int i = 0; i < 31; i++) begin
      if ((s > 0 && s < fma_pkg::MANT_HALF) ||
          (s < 0 && s > fma_pkg::MANT_NHALF)) begin
        s = s <<< 1;
        e = e - 18'sd1;
      end
    end
    if (s == '0) begin
      r = '0;
    end else if (e > fma_pkg::EXP_MAX) begin
      r.ovf = 1'b1;
      r.val.ex = fma_pkg::OVF_EXP;
      r.val.hi = s[33] ? fma_pkg::OVF_NEG_HI : fma_pkg::OVF_POS_HI;
      r.val.lo = s[33] ? fma_pkg::OVF_NEG_LO : fma_pkg::OVF_POS_LO;
    end else if (e < fma_pkg::EXP_MIN) begin
      r.ovf = 1'b1;
    end else begin
      r.val = {s[31:16], s[15:0], e[15:0]};
    end
    return r;
  endfunction : fma_addsub

  function automatic logic [15:0] word_of(
    input fma_pkg::fma_fp_t f,
    input logic [1:0] i
  );
    return (i == 2'h0) ? f.hi : ((i == 2'h1) ? f.lo : f.ex);
  endfunction : word_of

  assign calc = fma_addsub(scratch_float_acc_r, opd_r, op_r == fma_pkg::CMD_SUB);
  assign run_edge = run_s2_r && !run_s3_r;
  assign stop_edge = !run_s2_r && run_s3_r;
  assign pend_any = pend_stop_r || pend_run_r;

  // decode of the command taken this cycle
  always_comb begin
    take = cmd_valid && ready_r;
    fm_tgt = fm_r;
    float_go = 1'b0;
    if (take) begin
      unique case (cmd)
        fma_pkg::CMD_WD_C0: fm_tgt = cmd_data[fma_pkg::FM_BIT] && fpen_r;
        fma_pkg::CMD_LDX: if (arm_r) fm_tgt = cmd_data[fma_pkg::FM_BIT] && fpen_r;
        fma_pkg::CMD_BRANCH: fm_tgt = 1'b0;
        fma_pkg::CMD_INT_ENTRY: fm_tgt = 1'b0;
        fma_pkg::CMD_LOAD, fma_pkg::CMD_STORE, fma_pkg::CMD_ADD,
        fma_pkg::CMD_SUB: float_go = fm_r && fpen_r;
        default: fm_tgt = fm_r;
      endcase
    end
  end

  // compute switch synchroniser and edge capture
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {run_s3_r, run_s2_r, run_s1_r} <= 3'h0;
    end else begin
      {run_s3_r, run_s2_r, run_s1_r} <= {run_s2_r, run_s1_r, compute_run};
    end
  end

  // panel requests wait here until the sequencer is idle; a new edge wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {pend_stop_r, pend_run_r} <= 2'h0;
    end else if (stop_edge || run_edge) begin
      {pend_stop_r, pend_run_r} <= {stop_edge, run_edge};
    end else if (st_r == fma_pkg::ST_IDLE && !take) begin
      {pend_stop_r, pend_run_r} <= 2'h0;
    end
  end

  // sequencer, flag, accumulator and memory port
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= fma_pkg::ST_IDLE;
      op_r <= fma_pkg::CMD_NONE;
      fm_r <= 1'b0;
      arm_r <= 1'b0;
      ovf_r <= 1'b0;
      fm_save_r <= 1'b0;
      ready_r <= 1'b0;
      res_valid_r <= 1'b0;
      res_a_r <= '0;
      scratch_float_acc_r <= '0;
      opd_r <= '0;
      mem_req_r <= 1'b0;
      mem_r <= '0;
      wr_r <= 1'b0;
      base_r <= '0;
      idx_r <= '0;
    end else begin
      res_valid_r <= 1'b0;
      unique case (st_r)
        fma_pkg::ST_IDLE: begin
          ready_r <= !pend_any && !run_edge && !stop_edge;
          if (take) begin
            arm_r <= (cmd == fma_pkg::CMD_WD_D8);
            if (cmd == fma_pkg::CMD_INT_ENTRY) fm_save_r <= fm_r;
            if (cmd == fma_pkg::CMD_PSW_READ) begin
              res_a_r <= cmd_data;
              res_a_r[fma_pkg::FM_BIT] <= fm_r;
              res_valid_r <= 1'b1;
            end
            if (fm_tgt != fm_r) begin
              fm_r <= fm_tgt;
              op_r <= fma_pkg::CMD_NONE;
              wr_r <= !fm_tgt;
              st_r <= fma_pkg::ST_PTR;
              ready_r <= 1'b0;
            end else if (float_go) begin
              op_r <= cmd;
              base_r <= cmd_addr;
              idx_r <= '0;
              wr_r <= (cmd == fma_pkg::CMD_STORE);
              st_r <= fma_pkg::ST_XFER;
              ready_r <= 1'b0;
            end
          end else if (pend_any && fm_r) begin
            op_r <= fma_pkg::CMD_NONE;
            wr_r <= pend_stop_r;
            st_r <= fma_pkg::ST_PTR;
            ready_r <= 1'b0;
          end
        end
        fma_pkg::ST_PTR: begin
          if (!mem_req_r) begin
            mem_req_r <= 1'b1;
            mem_r <= '{we: 1'b0, addr: fma_pkg::ACC_PTR_ADDR, wdata: '0};
          end else if (mem_ack) begin
            mem_req_r <= 1'b0;
            base_r <= mem_rdata;
            idx_r <= '0;
            st_r <= fma_pkg::ST_XFER;
          end
        end
        fma_pkg::ST_XFER: begin
          if (!mem_req_r) begin
            mem_req_r <= 1'b1;
            mem_r.we <= wr_r;
            mem_r.addr <= base_r + {14'h0, idx_r};
            mem_r.wdata <= word_of(scratch_float_acc_r, idx_r);
          end else if (mem_ack) begin
            mem_req_r <= 1'b0;
            if (!wr_r && (op_r == fma_pkg::CMD_ADD ||
                          op_r == fma_pkg::CMD_SUB)) begin
              unique case (idx_r)
                2'h0: opd_r.hi <= mem_rdata;
                2'h1: opd_r.lo <= mem_rdata;
                default: opd_r.ex <= mem_rdata;
              endcase
            end else if (!wr_r) begin
              unique case (idx_r)
                2'h0: scratch_float_acc_r.hi <= mem_rdata;
                2'h1: scratch_float_acc_r.lo <= mem_rdata;
                default: scratch_float_acc_r.ex <= mem_rdata;
              endcase
            end
            idx_r <= idx_r + 2'h1;
            if (idx_r == fma_pkg::LAST_WORD) begin
              st_r <= (op_r == fma_pkg::CMD_ADD || op_r == fma_pkg::CMD_SUB)
                ? fma_pkg::ST_CALC : fma_pkg::ST_DONE;
            end
          end
        end
        fma_pkg::ST_CALC: begin
          scratch_float_acc_r <= calc.val;
          ovf_r <= calc.ovf;
          st_r <= fma_pkg::ST_DONE;
        end
        fma_pkg::ST_DONE: begin
          if (op_r != fma_pkg::CMD_NONE) begin
            res_a_r <= scratch_float_acc_r.hi;
            res_valid_r <= 1'b1;
          end
          st_r <= fma_pkg::ST_IDLE;
        end
        default: st_r <= fma_pkg::ST_IDLE;
      endcase
    end
  end

  // apb slave: answer in the cycle after setup
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      fpen_r <= fma_pkg::CTRL_FPEN_RST;
    end else begin
      pready_r <= psel && !penable;
      if (psel && !penable) begin
        pslverr_r <= !(paddr == fma_pkg::REG_CTRL ||
                       paddr == fma_pkg::REG_STATUS ||
                       paddr == fma_pkg::REG_AWORD);
        prdata_r <= '0;
        if (paddr == fma_pkg::REG_CTRL) begin
          prdata_r[fma_pkg::CTRL_FPEN_BIT] <= fpen_r;
        end else if (paddr == fma_pkg::REG_STATUS) begin
          prdata_r[fma_pkg::ST_FM_BIT] <= fm_r;
          prdata_r[fma_pkg::ST_OVF_BIT] <= ovf_r;
          prdata_r[fma_pkg::ST_BUSY_BIT] <= (st_r != fma_pkg::ST_IDLE);
          prdata_r[fma_pkg::ST_ARM_BIT] <= arm_r;
        end else if (paddr == fma_pkg::REG_AWORD) begin
          prdata_r[15:0] <= res_a_r;
        end
      end
      if (psel && penable && pready_r && pwrite &&
          paddr == fma_pkg::REG_CTRL) begin
        fpen_r <= pwdata[fma_pkg::CTRL_FPEN_BIT];
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign cmd_ready = ready_r;
  assign res_valid = res_valid_r;
  assign res_a = res_a_r;
  assign ovf_ind = ovf_r;
  assign float_mode_flag = fm_r;
  assign psd_fm_save = fm_save_r;
  assign mem_req = mem_req_r;
  assign mem_bus = mem_r;

  fm_c0_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take && cmd == fma_pkg::CMD_WD_C0 && fpen_r
    |=> fm_r == $past(cmd_data[fma_pkg::FM_BIT]))
    else $error("flag does not follow direct write");
  fm_ldx_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take && cmd == fma_pkg::CMD_LDX && arm_r && fpen_r
    |=> fm_r == $past(cmd_data[fma_pkg::FM_BIT]))
    else $error("flag not restored by index load");
  fm_reset_a: assert property (@(posedge clk_sys)
    !rst_n |=> !fm_r && st_r == fma_pkg::ST_IDLE && !mem_req_r)
    else $error("reset left flag or transfer active");
  br_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take && cmd == fma_pkg::CMD_BRANCH |=> !fm_r)
    else $error("branch did not clear flag");
  int_save_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take && cmd == fma_pkg::CMD_INT_ENTRY
    |=> psd_fm_save == $past(fm_r) && !fm_r)
    else $error("interrupt entry save wrong");
  clr_save_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(fm_r) |-> st_r == fma_pkg::ST_PTR && wr_r)
    else $error("flag clear without accumulator save");
  set_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(fm_r) |-> st_r == fma_pkg::ST_PTR && !wr_r)
    else $error("flag set without accumulator reload");
  addr_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(mem_req_r) && st_r == fma_pkg::ST_XFER && idx_r != 2'h0
    |-> mem_r.addr == $past(mem_r.addr) + 16'h1)
    else $error("transfer address out of order");
  busy_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_r != fma_pkg::ST_IDLE |-> !ready_r)
    else $error("command accepted while busy");
  calc_ovf_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_r == fma_pkg::ST_CALC |=> ovf_r == $past(calc.ovf)
      && st_r == fma_pkg::ST_DONE ##1 res_valid)
    else $error("overflow indicator or result wrong");

endmodule : fma_unit

// *** fma_mem_model.sv ***
// fma_mem_model: word memory on the far side of the accumulator unit
// assumes requests held until ack; slow adds three wait cycles
`timescale 1ns/10ps
module fma_mem_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic mem_req,
  input wire fma_pkg::fma_mem_t mem_bus,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:255];
  logic [1:0] wait_r;
  // read data only holds on the ack cycle, then it toggles
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rst_n) begin
      wait_r <= 2'h0;
    end else if (mem_req && !mem_ack) begin
      if (wait_r == (slow ? 2'h3 : 2'h0)) begin
        mem_ack <= 1'b1;
        wait_r <= 2'h0;
        if (mem_bus.we) mem[mem_bus.addr[7:0]] <= mem_bus.wdata;
        else mem_rdata <= mem[mem_bus.addr[7:0]];
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule : fma_mem_model

// *** fma_unit_tb.sv ***
// fma_unit_tb: self-checking bench for the float mode accumulator unit
// assumes fma_mem_model on the memory port, apb master tasks here
`timescale 1ns/10ps
module fma_unit_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic cmd_valid = 1'b0, cmd_ready, res_valid, ovf_ind, mem_req, mem_ack;
  fma_pkg::fma_cmd_t cmd = fma_pkg::CMD_NONE;
  logic [15:0] cmd_addr = 16'h0000, cmd_data = 16'h0000, res_a, mem_rdata;
  logic float_mode_flag, psd_fm_save, compute_run = 1'b0, slow = 1'b0;
  fma_pkg::fma_mem_t mem_bus;
  int failures = 0, n_checks = 0, cyc = 0;
  logic [15:0] ra;
  logic rv, err;
  fma_pkg::fma_cmd_t ops [8] = '{fma_pkg::CMD_ADD, fma_pkg::CMD_SUB,
    fma_pkg::CMD_ADD, fma_pkg::CMD_SUB, fma_pkg::CMD_ADD, fma_pkg::CMD_ADD,
    fma_pkg::CMD_ADD, fma_pkg::CMD_ADD};
  logic [47:0] av [8] = '{48'h400000000001, 48'h400000000002,
    48'h7FFFFFFF7FFF, 48'h400000008000, 48'h200000000003,
    48'h400000000001, 48'hC00000000001, 48'hC00000007FFF};
  logic [47:0] bv [8] = '{48'h400000000001, 48'h400000000002,
    48'h7FFFFFFF7FFF, 48'h400000018000, 48'h000000000000,
    48'h400000010000, 48'hC00000000001, 48'hC00000007FFF};
  logic [47:0] ev [8] = '{48'h400000000002, 48'h000000000000,
    48'h7FFFFFFF7FFF, 48'h000000000000, 48'h400000000002,
    48'h600000000001, 48'hC00000000002, 48'h800000017FFF};
  logic [7:0] ov = 8'h8C;
  fma_unit u_fma_unit (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cmd_valid, .cmd, .cmd_addr,
    .cmd_data, .cmd_ready, .res_valid, .res_a, .ovf_ind, .float_mode_flag,
    .psd_fm_save, .compute_run, .mem_req, .mem_bus, .mem_ack, .mem_rdata);
  fma_mem_model u_fma_mem_model (.clk_sys, .rst_n, .slow, .mem_req,
    .mem_bus, .mem_ack, .mem_rdata);
  always #12.5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [47:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic op(input fma_pkg::fma_cmd_t c, input logic [15:0] a, d);
    int n;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_addr <= a;
    cmd_data <= d;
    rv = 1'b0;
    n = 0;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk_sys);
      if (res_valid === 1'b1) begin
        rv = 1'b1;
        ra = res_a;
      end
      n++;
    end while (cmd_ready !== 1'b1 && n < 200);
  endtask : op
  task automatic put3(input logic [7:0] a, input logic [47:0] v);
    u_fma_mem_model.mem[a] = v[47:32];
    u_fma_mem_model.mem[a + 8'h1] = v[31:16];
    u_fma_mem_model.mem[a + 8'h2] = v[15:0];
  endtask : put3
  function automatic logic [47:0] get3(input logic [7:0] a);
    return {u_fma_mem_model.mem[a], u_fma_mem_model.mem[a + 8'h1],
      u_fma_mem_model.mem[a + 8'h2]};
  endfunction : get3
  task automatic t_apb;
    apb(1'b0, fma_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h1);
    apb(1'b0, fma_pkg::REG_STATUS, 32'h0);
    chk("status reset", rd, 32'h0);
    apb(1'b1, 12'h0FC, 32'hFFFFFFFF);
    chk("unmapped err", {err, rd}, 33'h100000000);
    apb(1'b1, fma_pkg::REG_CTRL, 32'h0);
    op(fma_pkg::CMD_WD_C0, 16'h0000, 16'h0040);
    chk("flag fpen off", float_mode_flag, 1'b0);
    apb(1'b1, fma_pkg::REG_CTRL, 32'h1);
    $display("test apb done");
  endtask : t_apb
  task automatic t_flag;
    put3(8'h80, 48'h400000000001);
    op(fma_pkg::CMD_WD_C0, 16'h0000, 16'h0040);
    chk("flag set", float_mode_flag, 1'b1);
    op(fma_pkg::CMD_STORE, 16'h0010, 16'h0000);
    chk("reloaded acc", get3(8'h10), 48'h400000000001);
    chk("store a", {rv, ra}, 17'h14000);
    apb(1'b0, fma_pkg::REG_STATUS, 32'h0);
    chk("status flag", rd[0], 1'b1);
    apb(1'b0, fma_pkg::REG_AWORD, 32'h0);
    chk("aword", rd, 32'h4000);
    $display("test flag done");
  endtask : t_flag
  task automatic t_arith;
    for (int i = 0; i < 8; i++) begin
      slow <= i[0];
      put3(8'h20, av[i]);
      put3(8'h30, bv[i]);
      op(fma_pkg::CMD_LOAD, 16'h0020, 16'h0000);
      chk("load a", {rv, ra}, {1'b1, av[i][47:32]});
      op(ops[i], 16'h0030, 16'h0000);
      chk("arith a", {rv, ra}, {1'b1, ev[i][47:32]});
      chk("ovf", ovf_ind, ov[i]);
      op(fma_pkg::CMD_STORE, 16'h0040, 16'h0000);
      chk("arith acc", get3(8'h40), ev[i]);
    end
    slow <= 1'b0;
    $display("test arith done");
  endtask : t_arith
  task automatic t_save;
    put3(8'h20, 48'h123456780009);
    op(fma_pkg::CMD_LOAD, 16'h0020, 16'h0000);
    op(fma_pkg::CMD_PSW_READ, 16'h0000, 16'h0000);
    chk("psw set", {rv, ra}, 17'h10040);
    op(fma_pkg::CMD_BRANCH, 16'h0000, 16'h0000);
    chk("branch clr", float_mode_flag, 1'b0);
    chk("save img", get3(8'h80), 48'h123456780009);
    op(fma_pkg::CMD_PSW_READ, 16'h0000, 16'hFFFF);
    chk("psw clr", {rv, ra}, 17'h1FFBF);
    op(fma_pkg::CMD_LOAD, 16'h0030, 16'h0000);
    chk("fixed load", rv, 1'b0);
    op(fma_pkg::CMD_LDX, 16'h0000, 16'h0040);
    chk("ldx unarmed", float_mode_flag, 1'b0);
    $display("test save done");
  endtask : t_save
  task automatic t_int;
    op(fma_pkg::CMD_WD_C0, 16'h0000, 16'h0040);
    put3(8'h20, 48'h2222333300AB);
    op(fma_pkg::CMD_LOAD, 16'h0020, 16'h0000);
    op(fma_pkg::CMD_INT_ENTRY, 16'h0000, 16'h0000);
    chk("int save", {psd_fm_save, float_mode_flag}, 2'b10);
    chk("int img", get3(8'h80), 48'h2222333300AB);
    put3(8'h80, 48'h500000000004);
    op(fma_pkg::CMD_WD_D8, 16'h0000, 16'h0000);
    op(fma_pkg::CMD_LDX, 16'h0000, 16'h0040);
    chk("exit flag", float_mode_flag, 1'b1);
    op(fma_pkg::CMD_STORE, 16'h0010, 16'h0000);
    chk("exit acc", get3(8'h10), 48'h500000000004);
    $display("test int done");
  endtask : t_int
  task automatic t_panel;
    put3(8'h80, 48'h600000000002);
    compute_run <= 1'b1;
    repeat (20) @(posedge clk_sys);
    op(fma_pkg::CMD_STORE, 16'h0010, 16'h0000);
    chk("run reload", get3(8'h10), 48'h600000000002);
    op(fma_pkg::CMD_LOAD, 16'h0020, 16'h0000);
    compute_run <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("idle save", get3(8'h80), 48'h2222333300AB);
    put3(8'h80, 48'hAAAA55550001);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("reset flag", float_mode_flag, 1'b0);
    chk("reset no save", get3(8'h80), 48'hAAAA55550001);
    $display("test panel done");
  endtask : t_panel
  initial begin
    u_fma_mem_model.mem[1] = 16'h0080;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_apb();
    t_flag();
    t_arith();
    t_save();
    t_int();
    t_panel();
    give_verdict();
  end
endmodule : fma_unit_tb
